// ---- phy_status_led_controller.v ----
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_consts.vh"
// Function
// - style latched from strap and bit at reset
// - bit 1, strap high: individual style
// - bit 1, strap low: tri-colour style
// - bit 0: enhanced style, strap ignored
// - individual: B link, A activity toggle
// - isolate forces off in individual, tri-colour
// - power-down forces off in all styles
// - tri-colour: B 1000, A 100, both 10
// - tri-colour: high unlinked, low idle, toggle active
// - enhanced: per-output function field, behaviour controls
// - function 0: link any speed, activity blinks off
// - functions 1-6: link at chosen speeds only
// - function 8: full duplex on, collisions blink on
// - function 9: collisions blink on
// - function 10: activity blinks on, tx-only option
// - function 12: auto-negotiation fault lights output
// - function 14 forced off, 15 forced on
// - blink 50% duty, four rates per output
// - pulse-stretch, four lengths per output
// - pulsing: 5 kHz 20% on asserted output
module phy_status_led_controller (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       style_strap_i,         // style strap level at reset
  input  wire       compat_style_select_i, // compatibility style bit
  input  wire       isolate_bit_i,         // isolate control
  input  wire       power_down_i,          // power-down control
  input  wire       link_up_i,             // link valid
  input  wire [1:0] speed_i,               // link speed
  input  wire       full_duplex_i,         // duplex status
  input  wire       rx_act_i,              // receive activity
  input  wire       tx_act_i,              // transmit activity
  input  wire       collision_i,           // collision seen
  input  wire       aneg_fault_i,          // auto-negotiation fault
  input  wire [3:0] func_a_i,              // enhanced function, output a
  input  wire [3:0] func_b_i,              // enhanced function, output b
  input  wire [1:0] rate_a_i,              // blink/stretch rate, output a
  input  wire [1:0] rate_b_i,              // blink/stretch rate, output b
  input  wire       stretch_a_i,           // 1 stretch, 0 blink, output a
  input  wire       stretch_b_i,           // 1 stretch, 0 blink, output b
  input  wire       tx_only_act_i,         // activity output select
  input  wire       pulsing_en_i,          // pulsing option
  output reg        indicator_out_a_o,     // output a, low is on
  output reg        indicator_out_b_o      // output b, low is on
);
  // derived timing counts, worked out at full integer width first
  localparam [31:0] BL0_W = `US_TO_CYC(`BLINK_HALF_US_0);
  localparam [31:0] BL1_W = `US_TO_CYC(`BLINK_HALF_US_1);
  localparam [31:0] BL2_W = `US_TO_CYC(`BLINK_HALF_US_2);
  localparam [31:0] BL3_W = `US_TO_CYC(`BLINK_HALF_US_3);
  localparam [31:0] ST0_W = `US_TO_CYC(`STRETCH_US_0);
  localparam [31:0] ST1_W = `US_TO_CYC(`STRETCH_US_1);
  localparam [31:0] ST2_W = `US_TO_CYC(`STRETCH_US_2);
  localparam [31:0] ST3_W = `US_TO_CYC(`STRETCH_US_3);
  localparam [31:0] PER_W = `PULSE_PERIOD_CYC;
  localparam [31:0] PON_W = `PULSE_ON_CYC;
  // cut to the counter widths: the longest stretch, 8,000,000 cycles,
  // still fits the 24-bit shaper counter, and 4000 fits 12 bits
  localparam [23:0] BL0   = BL0_W[23:0];
  localparam [23:0] BL1   = BL1_W[23:0];
  localparam [23:0] BL2   = BL2_W[23:0];
  localparam [23:0] BL3   = BL3_W[23:0];
  localparam [23:0] ST0   = ST0_W[23:0];
  localparam [23:0] ST1   = ST1_W[23:0];
  localparam [23:0] ST2   = ST2_W[23:0];
  localparam [23:0] ST3   = ST3_W[23:0];
  localparam [11:0] PER   = PER_W[11:0];
  localparam [11:0] PON   = PON_W[11:0];

  // style and timing state
  reg  [2:0]  style_r;          // latched display style, one-hot
  reg  [2:0]  strap_sync_r;     // strap synchroniser, bit 0 first
  reg         strap_f_r;        // strap level once two stages agree
  reg         rst_seen_r;       // reset was active last cycle
  reg  [11:0] pcnt_r;           // pulsing modulation counter

  // next levels and lane results
  reg         a_nxt;            // next level output a
  reg         b_nxt;            // next level output b
  wire [1:0]  ev;               // per-output event levels for shapers
  wire [1:0]  shp;              // shaped events
  wire [1:0]  on_en;            // enhanced asserted level per output

  // decoded status; speed 3 matches none of the three speeds
  wire        act   = rx_act_i | tx_act_i;
  wire        act_e = tx_only_act_i ? tx_act_i : act;
  wire        l1000 = link_up_i & (speed_i == `SPD_1000);
  wire        l100  = link_up_i & (speed_i == `SPD_100);
  wire        l10   = link_up_i & (speed_i == `SPD_10);
  wire        pulse_on = (pcnt_r < PON);
  wire        pulse_gate = !pulsing_en_i || pulse_on;

  // per-lane control views: index 0 is output a, index 1 output b
  wire [3:0]  fn [0:1];         // per-output function
  wire [1:0]  rt [0:1];         // per-output rate
  wire        se [0:1];         // per-output stretch select

  assign fn[0] = func_a_i;
  assign fn[1] = func_b_i;
  assign rt[0] = rate_a_i;
  assign rt[1] = rate_b_i;
  assign se[0] = stretch_a_i;
  assign se[1] = stretch_b_i;

  // the strap is a board pin: three flops, and a new level is taken only
  // once the second and third agree, so a bouncing strap cannot glitch it
  always @(posedge clk_i) begin
    strap_sync_r <= {strap_sync_r[1:0], style_strap_i};
    if (strap_sync_r[2] == strap_sync_r[1])
      strap_f_r <= strap_sync_r[1];
  end

  // style capture on the first edge after reset release; the strap must
  // stand at least four edges before release to pass the synchroniser,
  // and later changes of strap or bit are ignored until the next reset
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      // enhanced while in reset
      rst_seen_r <= 1'b1;
      style_r    <= `STYLE_ENH;
    end else begin
      rst_seen_r <= 1'b0;
      if (rst_seen_r) begin
        if (!compat_style_select_i) begin
          // compatibility bit clear: strap has no say
          style_r <= `STYLE_ENH;
        end else if (strap_f_r) begin
          // strap pulled high
          style_r <= `STYLE_INDIV;
        end else begin
          // strap pulled low
          style_r <= `STYLE_TRI;
        end
      end
    end
  end

  // 5 kHz pulsing counter: free-running, so both outputs pulse in step
  // and the glow phase does not depend on when pulsing was enabled
  always @(posedge clk_i) begin
    if (!rst_n_i)
      pcnt_r <= 12'h000;                            // restart the period
    else if (pcnt_r == PER - 12'h001)
      pcnt_r <= 12'h000;                            // wrap after 4000 cycles
    else
      pcnt_r <= pcnt_r + 12'h001;
  end

  // per-output shaper and enhanced function decode; lane 0 serves output a
  // and lane 1 output b, and the fixed styles look at lane 0 only
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_out
      reg  spd_ok;                                  // link at chosen speeds
      reg  ev_lvl;                                  // event level of this lane
      reg  on_lvl;                                  // enhanced asserted level
      assign ev[g]    = ev_lvl;
      assign on_en[g] = on_lvl;

      // speed match per function code; other codes never count a link
      always @* begin
        spd_ok = 1'b0;
        case (fn[g])
          `FN_LINK_ACT:     spd_ok = link_up_i;
          `FN_LINK1000:     spd_ok = l1000;
          `FN_LINK100:      spd_ok = l100;
          `FN_LINK10:       spd_ok = l10;
          `FN_LINK100_1000: spd_ok = l100 | l1000;
          `FN_LINK10_1000:  spd_ok = l10 | l1000;
          `FN_LINK10_100:   spd_ok = l10 | l100;
          default:          spd_ok = 1'b0;
        endcase
      end

      // shaper event source per style and function
      always @* begin
        ev_lvl = 1'b0;
        if (style_r != `STYLE_ENH) begin
          // fixed styles: any traffic blinks
          ev_lvl = act;
        end else if (fn[g] <= `FN_LINK10_100) begin
          // link functions: traffic on a counted link
          ev_lvl = spd_ok & act;
        end else if (fn[g] == `FN_DUPLEX_COL) begin
          // collisions only matter on a half-duplex link
          ev_lvl = link_up_i & ~full_duplex_i & collision_i;
        end else if (fn[g] == `FN_COLLISION) begin
          // any collision
          ev_lvl = collision_i;
        end else if (fn[g] == `FN_ACTIVITY) begin
          // traffic, or transmit only when selected
          ev_lvl = act_e;
        end else begin
          // steady functions need no shaping
          ev_lvl = 1'b0;
        end
      end

      // fixed styles blink at 10 Hz with no stretch; enhanced lanes take
      // their own rate and mode
      led_event_shaper #(
        // phase lengths in core clock cycles
        .BLINK0_CYC   (BL0),
        .BLINK1_CYC   (BL1),
        .BLINK2_CYC   (BL2),
        .BLINK3_CYC   (BL3),
        .STRETCH0_CYC (ST0),
        .STRETCH1_CYC (ST1),
        .STRETCH2_CYC (ST2),
        .STRETCH3_CYC (ST3)
      ) u_shaper (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .event_i   (ev[g]),
        .stretch_i (style_r == `STYLE_ENH ? se[g] : 1'b0),
        .rate_i    (style_r == `STYLE_ENH ? rt[g] : 2'h2),
        .shaped_o  (shp[g])
      );

      // enhanced asserted level; 1 means the led should glow
      always @* begin
        on_lvl = 1'b0;
        case (fn[g])
          // link functions: lit on a counted link, traffic blinks it off
          `FN_LINK_ACT, `FN_LINK1000, `FN_LINK100, `FN_LINK10,
          `FN_LINK100_1000, `FN_LINK10_1000, `FN_LINK10_100:
            on_lvl = spd_ok & ~shp[g];
          // full duplex lit, half-duplex collisions blink it on
          `FN_DUPLEX_COL:
            on_lvl = (link_up_i & full_duplex_i) | shp[g];
          // event functions: dark until the shaper shows an event
          `FN_COLLISION:  on_lvl = shp[g];
          `FN_ACTIVITY:   on_lvl = shp[g];
          // steady functions follow a level or a constant
          `FN_ANEG_FAULT: on_lvl = aneg_fault_i;
          `FN_FORCE_OFF:  on_lvl = 1'b0;
          `FN_FORCE_ON:   on_lvl = 1'b1;
          // reserved codes stay dark
          default:        on_lvl = 1'b0;
        endcase
      end
    end
  endgenerate

  // output level select per style; outputs are active low, so off is high
  always @* begin
    a_nxt = `LED_OFF;
    b_nxt = `LED_OFF;
    case (style_r)
      `STYLE_INDIV: begin
        // b shows link at any speed
        b_nxt = link_up_i ? `LED_ON : `LED_OFF;
        // a is dark when idle and glows in the shaper's on phases
        a_nxt = (act && shp[0]) ? `LED_ON : `LED_OFF;
      end
      `STYLE_TRI: begin
        // b serves 1000 and 10, a serves 100 and 10; unused stays high
        // with traffic the used outputs go high in the shaper's on phases
        if (l1000 || l10)
          b_nxt = (act && shp[0]) ? `LED_OFF : `LED_ON;
        if (l100 || l10)
          a_nxt = (act && shp[0]) ? `LED_OFF : `LED_ON;
      end
      `STYLE_ENH: begin
        // asserted level, chopped by the pulsing gate
        a_nxt = (on_en[0] && pulse_gate) ? `LED_ON : `LED_OFF;
        b_nxt = (on_en[1] && pulse_gate) ? `LED_ON : `LED_OFF;
      end
      default: begin
        // no legal style latched: stay dark
        a_nxt = `LED_OFF;
        b_nxt = `LED_OFF;
      end
    endcase
    // isolate darkens the fixed styles only
    if (isolate_bit_i && style_r != `STYLE_ENH) begin
      a_nxt = `LED_OFF;
      b_nxt = `LED_OFF;
    end
    // power-down wins over everything
    if (power_down_i) begin
      a_nxt = `LED_OFF;
      b_nxt = `LED_OFF;
    end
  end

  // registered outputs, so each pin comes straight from a flop; status
  // inputs are synchronous core signals and need no synchroniser
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      // dark through reset
      indicator_out_a_o <= `LED_OFF;
      indicator_out_b_o <= `LED_OFF;
    end else begin
      indicator_out_a_o <= a_nxt;
      indicator_out_b_o <= b_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- led_ctrl_consts.vh ----
`ifndef LED_CTRL_CONSTS_VH
`define LED_CTRL_CONSTS_VH
// clock rate
`define CLK_HZ            20000000
// display styles (one-hot)
`define STYLE_INDIV       3'h1
`define STYLE_TRI         3'h2
`define STYLE_ENH         3'h4
// indicator levels: active low
`define LED_ON            1'b0
`define LED_OFF           1'b1
// speed encoding of speed_i
`define SPD_10            2'h0
`define SPD_100           2'h1
`define SPD_1000          2'h2
// enhanced functions
`define FN_LINK_ACT       4'h0
`define FN_LINK1000       4'h1
`define FN_LINK100        4'h2
`define FN_LINK10         4'h3
`define FN_LINK100_1000   4'h4
`define FN_LINK10_1000    4'h5
`define FN_LINK10_100     4'h6
`define FN_DUPLEX_COL     4'h8
`define FN_COLLISION      4'h9
`define FN_ACTIVITY       4'hA
`define FN_ANEG_FAULT     4'hC
`define FN_FORCE_OFF      4'hE
`define FN_FORCE_ON       4'hF
// blink half periods in microseconds: 2.5/5/10/20 Hz -> 200/100/50/25 ms
`define BLINK_HALF_US_0   200000
`define BLINK_HALF_US_1   100000
`define BLINK_HALF_US_2   50000
`define BLINK_HALF_US_3   25000
// pulse-stretch lengths in microseconds
`define STRETCH_US_0      50000
`define STRETCH_US_1      100000
`define STRETCH_US_2      200000
`define STRETCH_US_3      400000
// pulsing 5 kHz, 20% duty
`define PULSE_HZ          5000
`define PULSE_DUTY_PCT    20
`define PULSE_PERIOD_CYC  (`CLK_HZ / `PULSE_HZ)
`define PULSE_ON_CYC      (`PULSE_PERIOD_CYC * `PULSE_DUTY_PCT / 100)
`define US_TO_CYC(us)     ((us) * (`CLK_HZ / 1000000))
`endif

// ---- led_event_shaper.v ----
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_consts.vh"
// per-output blink or pulse-stretch shaping of an event level
module led_event_shaper #(
  parameter [23:0] BLINK0_CYC   = 24'h3D0900,
  parameter [23:0] BLINK1_CYC   = 24'h1E8480,
  parameter [23:0] BLINK2_CYC   = 24'h0F4240,
  parameter [23:0] BLINK3_CYC   = 24'h07A120,
  parameter [23:0] STRETCH0_CYC = 24'h0F4240,
  parameter [23:0] STRETCH1_CYC = 24'h1E8480,
  parameter [23:0] STRETCH2_CYC = 24'h3D0900,
  parameter [23:0] STRETCH3_CYC = 24'h7A1200
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       event_i,     // event level
  input  wire       stretch_i,   // 1 pulse-stretch, 0 blink
  input  wire [1:0] rate_i,      // rate select
  output reg        shaped_o     // 1 while shaped event shown
);
  reg  [23:0] cnt_r;             // phase counter
  reg         hold_r;            // stretch hold pending
  reg  [23:0] len;               // selected phase length
  wire        last = (cnt_r >= len - 24'h000001);

  // phase length mux
  always @* begin
    len = BLINK0_CYC;
    case ({stretch_i, rate_i})
      3'h0:    len = BLINK0_CYC;
      3'h1:    len = BLINK1_CYC;
      3'h2:    len = BLINK2_CYC;
      3'h3:    len = BLINK3_CYC;
      3'h4:    len = STRETCH0_CYC >> 1;  // half-period phases
      3'h5:    len = STRETCH1_CYC >> 1;
      3'h6:    len = STRETCH2_CYC >> 1;
      default: len = STRETCH3_CYC >> 1;
    endcase
  end

  // shaping state: in blink mode toggles every phase while events persist
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r    <= 24'h000000;
      hold_r   <= 1'b0;
      shaped_o <= 1'b0;
    end else if (!shaped_o && cnt_r == 24'h000000) begin
      // idle: start on an event
      if (event_i) begin
        shaped_o <= 1'b1;
        cnt_r    <= 24'h000001;
        hold_r   <= 1'b1;              // a single stretched event lasts two phases
      end
    end else begin
      if (event_i)
        hold_r <= 1'b1;
      if (last) begin
        hold_r <= 1'b0;
        if (!shaped_o) begin
          // off phase over: idle with the hold cleared, an event still present restarts on the next edge
          cnt_r <= 24'h000000;
        end else if (stretch_i && (hold_r || event_i)) begin
          // stretch: another on phase while events keep arriving
          cnt_r <= 24'h000000;
        end else begin
          // on phase over: a full off phase follows, keeping blink at 50%
          shaped_o <= 1'b0;
          cnt_r    <= 24'h000001;
        end
      end else begin
        cnt_r <= cnt_r + 24'h000001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- led_ctrl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_consts.vh"
module led_ctrl_monitor (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       style_strap_i,
  input  wire       compat_style_select_i,
  input  wire       isolate_bit_i,
  input  wire       power_down_i,
  input  wire       link_up_i,
  input  wire [1:0] speed_i,
  input  wire [3:0] func_a_i,
  input  wire [3:0] func_b_i,
  input  wire       aneg_fault_i,
  input  wire       pulsing_en_i,
  input  wire       indicator_out_a_o,
  input  wire       indicator_out_b_o
);
  reg  prev_r;   // reset level one edge ago
  reg  cap_r;    // style captured
  reg  compat_r; // captured compatibility bit
  reg  strap_r;  // captured strap
  wire enh;      // enhanced style in force
  wire dark;     // both outputs off
  assign enh = cap_r && !compat_r;
  assign dark = indicator_out_a_o == `LED_OFF && indicator_out_b_o == `LED_OFF;
  // style capture at first edge after release
  always @(posedge clk_i) begin
    prev_r <= rst_n_i;
    if (!rst_n_i) begin
      cap_r <= 1'b0;
    end else if (!prev_r) begin
      cap_r <= 1'b1;
      compat_r <= compat_style_select_i;
      strap_r <= style_strap_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  power_down_off_a : assert property (power_down_i |=> dark)
    else $error("outputs lit in power-down");
  isolate_off_a : assert property (cap_r && compat_r && isolate_bit_i |=> dark)
    else $error("outputs lit while isolated");
  indiv_link_a : assert property (cap_r && compat_r && strap_r && !power_down_i
    && !isolate_bit_i |=> indicator_out_b_o != $past(link_up_i))
    else $error("link output wrong");
  tri_unlinked_a : assert property (cap_r && compat_r && !strap_r && !link_up_i
    && !power_down_i && !isolate_bit_i |=> dark)
    else $error("tri-colour lit without link");
  force_off_a : assert property (enh && func_a_i == `FN_FORCE_OFF
    |=> indicator_out_a_o == `LED_OFF)
    else $error("forced-off output lit");
  force_on_a : assert property (enh && func_b_i == `FN_FORCE_ON && !power_down_i
    && !pulsing_en_i |=> indicator_out_b_o == `LED_ON)
    else $error("forced-on output dark");
  aneg_fault_a : assert property (enh && func_a_i == `FN_ANEG_FAULT && !power_down_i
    && !pulsing_en_i |=> indicator_out_a_o != $past(aneg_fault_i))
    else $error("fault output wrong");
  reserved_off_a : assert property (enh && func_b_i inside {4'h7, 4'hB, 4'hD}
    |=> indicator_out_b_o == `LED_OFF)
    else $error("reserved function lit");
  speed_miss_a : assert property (enh && func_a_i == `FN_LINK10 && speed_i != `SPD_10
    |=> indicator_out_a_o == `LED_OFF)
    else $error("wrong-speed output lit");
endmodule
bind phy_status_led_controller led_ctrl_monitor led_ctrl_monitor_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .style_strap_i(style_strap_i),
  .compat_style_select_i(compat_style_select_i), .isolate_bit_i(isolate_bit_i),
  .power_down_i(power_down_i), .link_up_i(link_up_i), .speed_i(speed_i),
  .func_a_i(func_a_i), .func_b_i(func_b_i), .aneg_fault_i(aneg_fault_i),
  .pulsing_en_i(pulsing_en_i), .indicator_out_a_o(indicator_out_a_o),
  .indicator_out_b_o(indicator_out_b_o));
`default_nettype wire

// ---- led_pair_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// two leds with series resistors, glowing while the pin sinks current
module led_pair_model (
  input  wire pin_a_i, // output a level
  input  wire pin_b_i, // output b level
  output wire lit_a_o, // led a glowing
  output wire lit_b_o  // led b glowing
);
  // an unknown level never counts as glowing
  assign lit_a_o = (pin_a_i === 1'b0);
  assign lit_b_o = (pin_b_i === 1'b0);
endmodule
`default_nettype wire

// ---- test_phy_status_led_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_consts.vh"
module test_phy_status_led_controller;
  logic       clk_i = 1'b0;   // core clock
  logic       rst_n_i = 1'b0; // synchronous reset
  logic       strap = 1'b0;   // style strap
  logic       compat = 1'b0;  // compatibility bit
  logic [7:0] sta = 8'h00;    // link, speed[1:0], duplex, rx, tx, collision, fault
  logic [3:0] opt = 4'h0;     // isolate, power-down, tx-only, pulsing
  logic [3:0] fa = 4'h0;      // function, output a
  logic [3:0] fb = 4'h0;      // function, output b
  wire        out_a;          // output a level
  wire        out_b;          // output b level
  wire        lit_a;          // led a glowing
  wire        lit_b;          // led b glowing
  int         n_errors = 0;   // mismatches
  int         check_count = 0; // comparisons
  int         cyc = 0;        // cycle count for timeout
  int         lows;           // glowing cycles seen
  logic [2:0] mask [0:6] = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h6, 3'h5, 3'h3}; // speeds lit per fn
  always #25 clk_i = ~clk_i;
  phy_status_led_controller phy_status_led_controller_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .style_strap_i(strap), .compat_style_select_i(compat),
    .isolate_bit_i(opt[3]), .power_down_i(opt[2]), .link_up_i(sta[7]), .speed_i(sta[6:5]),
    .full_duplex_i(sta[4]), .rx_act_i(sta[3]), .tx_act_i(sta[2]), .collision_i(sta[1]),
    .aneg_fault_i(sta[0]), .func_a_i(fa), .func_b_i(fb), .rate_a_i(2'h2), .rate_b_i(2'h2),
    .stretch_a_i(1'b0), .stretch_b_i(1'b0), .tx_only_act_i(opt[1]), .pulsing_en_i(opt[0]),
    .indicator_out_a_o(out_a), .indicator_out_b_o(out_b));
  led_pair_model led_pair_model_i (.pin_a_i(out_a), .pin_b_i(out_b),
    .lit_a_o(lit_a), .lit_b_o(lit_b));
  task automatic close_out;
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // both output levels against expectation
  task automatic cmp(input logic ea, input logic eb);
    check_count++;
    if (out_a !== ea || out_b !== eb) begin
      n_errors++;
      $display("Error at %0t: outputs %b%b, expected %b%b", $time, out_a, out_b, ea, eb);
    end
  endtask
  // a cycle count against expectation
  task automatic cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_errors++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  // lets registered output and shaper settle
  task automatic step;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic apply(input logic [7:0] s, input logic [3:0] o, input logic [3:0] a,
                       input logic [3:0] b);
    @(posedge clk_i);
    sta <= s;
    opt <= o;
    fa <= a;
    fb <= b;
    step;
  endtask
  // reset held six cycles with new style inputs
  task automatic restart(input logic s, input logic c);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    strap <= s;
    compat <= c;
    sta <= 8'h00;
    opt <= 4'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    step;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    restart(1'b1, 1'b1);
    apply(8'h00, 4'h0, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    apply(8'hA0, 4'h0, 4'h0, 4'h0); cmp(1'b1, 1'b0);
    apply(8'hA8, 4'h0, 4'h0, 4'h0); cmp(1'b0, 1'b0);
    apply(8'hA8, 4'h8, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    apply(8'hA8, 4'h4, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    restart(1'b0, 1'b1);
    apply(8'h00, 4'h0, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apply({1'b1, i[1:0], 5'h00}, 4'h0, 4'h0, 4'h0); cmp(i == 2, i == 1);
    end
    apply(8'h80, 4'h8, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    apply(8'hC8, 4'h0, 4'h0, 4'h0); cmp(1'b1, 1'b1);
    restart(1'b1, 1'b0);
    for (int f = 0; f < 7; f++) begin
      for (int s = 0; s < 3; s++) begin
        apply({1'b1, s[1:0], 5'h00}, 4'h0, f[3:0], 4'hF); cmp(!mask[f][s], 1'b0);
      end
    end
    apply(8'h90, 4'h0, 4'hE, 4'h8); cmp(1'b1, 1'b0);
    apply(8'h80, 4'h0, 4'hE, 4'h8); cmp(1'b1, 1'b1);
    apply(8'h80, 4'h0, 4'hE, 4'h9); cmp(1'b1, 1'b1);
    apply(8'h01, 4'h0, 4'hC, 4'h7); cmp(1'b0, 1'b1);
    apply(8'h00, 4'h0, 4'hC, 4'hB); cmp(1'b1, 1'b1);
    apply(8'h80, 4'h0, 4'hE, 4'hD); cmp(1'b1, 1'b1);
    apply(8'h88, 4'h2, 4'hA, 4'h9); cmp(1'b1, 1'b1);
    apply(8'h86, 4'h2, 4'hA, 4'h9); cmp(1'b0, 1'b0);
    apply(8'h86, 4'h0, 4'h0, 4'hF); cmp(1'b1, 1'b0);
    apply(8'h80, 4'h8, 4'hE, 4'hF); cmp(1'b1, 1'b0);
    apply(8'h80, 4'h1, 4'hE, 4'hF);
    lows = 0;
    repeat (`PULSE_PERIOD_CYC) begin
      @(posedge clk_i);
      #1;
      lows += lit_b + lit_a;
    end
    cnt(lows, `PULSE_PERIOD_CYC * `PULSE_DUTY_PCT / 100);
    apply(8'h90, 4'h4, 4'hF, 4'hF); cmp(1'b1, 1'b1);
    close_out;
  end
endmodule
`default_nettype wire
